// File: hw/ssp_pkg.sv
package ssp_pkg;

	// register offsets on the 8-bit register port
	localparam logic [7:0] ADDR_RUN_CONTROL = 8'hA0;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'hA4;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hA5;
	localparam logic [7:0] ADDR_EVENT_STATUS_MASK = 8'hA6;
	localparam logic [7:0] ADDR_TIMER_INITIAL_COUNT = 8'hA7;
	localparam logic [7:0] ADDR_FAST_SLEW_CONTROL = 8'hA8;
	localparam logic [7:0] ADDR_RANDOM_SEQ_PRESCALER_CONTROL = 8'hA9;
	localparam logic [7:0] ADDR_CURRENT_DAC_VALUE = 8'hFD;

	// run control field positions
	localparam int RUN_ENABLE_BIT = 0;
	localparam int RUN_CSD_MODE_BIT = 1;
	localparam int RUN_PRS_CLOCK_BIT = 2;

	// event status / mask field positions
	localparam int INPUT_EDGE_FLAG_BIT = 7;
	localparam int LOW_CARRY_FLAG_BIT = 6;
	localparam int HIGH_CARRY_FLAG_BIT = 5;
	localparam int MEASURE_DONE_FLAG_BIT = 4;
	localparam int FLAG_MSB = 7;
	localparam int FLAG_LSB = 4;
	localparam int MASK_MSB = 3;
	localparam int MASK_LSB = 0;

	// timer and slew fields
	localparam int TIMER_COUNT_MSB = 6;
	localparam int SLEW_COUNT_MSB = 7;
	localparam int SLEW_COUNT_LSB = 1;
	localparam int SLEW_ENABLE_BIT = 0;

	// random sequence / prescaler control fields
	localparam int CLOCK_OUT_BIT = 7;
	localparam int CLOCK_INVERT_BIT = 6;
	localparam int RANDOM_LEN_BIT = 5;
	localparam int RANDOM_ENABLE_BIT = 4;
	localparam int DIVIDER_BYPASS_BIT = 3;
	localparam int DIVIDER_SELECT_MSB = 2;

	// values after reset, and the counter all-ones compare value
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [11:0] RANDOM_SEED = 12'h001;
	localparam logic [7:0] COUNT_ALL_ONES = 8'hFF;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ssp_bus_req_t;

	typedef struct packed {
		logic [7:0] run_control;
		logic [7:0] event_status_mask;
		logic [7:0] timer_initial_count;
		logic [7:0] fast_slew_control;
		logic [7:0] random_seq_prescaler_control;
		logic [7:0] current_dac_value;
		logic [7:0] count_low;
		logic [7:0] count_high;
		logic event_in_prev;
		logic osc_prev;
		logic [6:0] slew_left;
		logic [7:0] divider_count;
		logic [11:0] random_state;
		logic [7:0] rdata;
		logic block_irq;
		logic fast_slew;
		logic random_out;
		logic clock_pin;
		logic [7:0] dac_code;
	} ssp_state_t;

endpackage

// File: hw/ssp_sense_regs.sv
// Contract
// - status bits 7..4 clear by writing zero or by disabling; writing one leaves them.
// - flags update only while enabled; disabling clears all flags.
// - bit 7 sets on rising edge of selected event input.
// - bit 6 sets on low byte counter overflow.
// - bit 5 sets on high byte counter overflow.
// - bit 4 sets when pulse width or period measurement completes.
// - mask bits 3..0 gate the four events onto the block interrupt.
// - timer register bits 6..0 give the timer initial count.
// - slew bits 7..1 set fast slew length in i_mclk cycles from each oscillator edge, both edges.
// - slew bit 0 enables fast slew; otherwise count has no effect.
// - clock-out bit 7 puts the sensing clock on the primary pin.
// - bit 6 inverts the sensing clock driven to the pin.
// - bit 5 picks MSB of 8-bit or 12-bit random sequence.
// - bit 4 enables random generator; disabled output holds zero.
// - prescaler clocks the generator; bypass bit 3 passes clock undivided; the pin square in bypass shows div 2.
// - divide codes 000..111 select division by 2 up to 256.
// - current DAC register value drives the DAC code when DAC mode on.
// - enable one counts; zero stops and clears both counters.
`timescale 1ns/1ns
module ssp_sense_regs (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst,
	// register port
	input wire ssp_pkg::ssp_bus_req_t i_bus,
	output logic [7:0] o_rdata,
	// sensing events
	input wire logic i_event_in,
	input wire logic i_measure_done,
	input wire logic i_relax_osc,
	input wire logic i_selected_clock,
	input wire logic i_normal_output,
	input wire logic i_dac_mode,
	// block outputs
	output logic o_block_irq,
	output logic [6:0] o_timer_initial_count,
	output logic o_fast_slew,
	output logic o_random_out,
	output logic o_clock_pin,
	output logic [7:0] o_current_dac_code
);
	import ssp_pkg::*;

	ssp_state_t state;
	ssp_state_t next_state;

	// one-hot style check used by the write decode only
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		hit = (addr == reg_addr);
	endfunction

	// next step of the 8 or 12 bit maximal-length sequence
	function automatic logic [11:0] lfsr_step(input logic [11:0] s, input logic long_len);
		logic fb;
		fb = 1'b0;
		if (long_len) begin
			fb = s[11] ^ s[5] ^ s[3] ^ s[0];
			lfsr_step = {s[10:0], fb};
		end else begin
			fb = s[7] ^ s[5] ^ s[4] ^ s[3];
			lfsr_step = {4'h0, s[6:0], fb};
		end
	endfunction

	logic enabled;
	logic [7:0] prs_ctl;
	logic [2:0] div_code;
	logic [7:0] div_low_mask;
	logic div_tick;
	logic div_square;
	logic low_carry;
	logic high_carry;
	logic edge_seen;
	logic [3:0] events;
	logic [3:0] clear_flags;
	logic [3:0] flags_now;
	logic osc_edge;
	logic sense_clock;
	logic [7:0] rd_mux;

	always_comb begin
		next_state = state;
		enabled = state.run_control[RUN_ENABLE_BIT];
		prs_ctl = state.random_seq_prescaler_control;
		div_code = prs_ctl[DIVIDER_SELECT_MSB:0];
		low_carry = 1'b0;
		high_carry = 1'b0;
		events = 4'h0;
		clear_flags = 4'h0;
		rd_mux = RESET_BYTE;

		// register writes
		if (i_bus.wr) begin
			if (hit(i_bus.addr, ADDR_RUN_CONTROL)) begin
				next_state.run_control = i_bus.wdata;
			end
			if (hit(i_bus.addr, ADDR_EVENT_STATUS_MASK)) begin
				// masks take the written value; software keeps flags with ones
				next_state.event_status_mask[MASK_MSB:MASK_LSB] =
					i_bus.wdata[MASK_MSB:MASK_LSB];
				clear_flags = ~i_bus.wdata[FLAG_MSB:FLAG_LSB];
			end
			if (hit(i_bus.addr, ADDR_TIMER_INITIAL_COUNT)) begin
				next_state.timer_initial_count = {1'b0, i_bus.wdata[TIMER_COUNT_MSB:0]};
			end
			if (hit(i_bus.addr, ADDR_FAST_SLEW_CONTROL)) begin
				next_state.fast_slew_control = i_bus.wdata;
			end
			if (hit(i_bus.addr, ADDR_RANDOM_SEQ_PRESCALER_CONTROL)) begin
				next_state.random_seq_prescaler_control = i_bus.wdata;
			end
			if (hit(i_bus.addr, ADDR_CURRENT_DAC_VALUE)) begin
				next_state.current_dac_value = i_bus.wdata;
			end
		end

		// byte counters: low counts every cycle, high counts low carries
		if (enabled) begin
			low_carry = (state.count_low == COUNT_ALL_ONES);
			next_state.count_low = state.count_low + 8'h01;
			if (low_carry) begin
				high_carry = (state.count_high == COUNT_ALL_ONES);
				next_state.count_high = state.count_high + 8'h01;
			end
		end else begin
			next_state.count_low = RESET_BYTE;
			next_state.count_high = RESET_BYTE;
		end

		// event input rising edge, inputs are already synchronous
		next_state.event_in_prev = i_event_in;
		edge_seen = i_event_in & ~state.event_in_prev;

		events[INPUT_EDGE_FLAG_BIT - FLAG_LSB] = edge_seen;
		events[LOW_CARRY_FLAG_BIT - FLAG_LSB] = low_carry;
		events[HIGH_CARRY_FLAG_BIT - FLAG_LSB] = high_carry;
		events[MEASURE_DONE_FLAG_BIT - FLAG_LSB] = i_measure_done;

		// an event in the clearing cycle wins over the clear
		flags_now = state.event_status_mask[FLAG_MSB:FLAG_LSB];
		if (enabled) begin
			next_state.event_status_mask[FLAG_MSB:FLAG_LSB] =
				(flags_now & ~clear_flags) | events;
		end else begin
			next_state.event_status_mask[FLAG_MSB:FLAG_LSB] = 4'h0;
		end

		// interrupt from the flags as they stand, gated by masks
		next_state.block_irq = |(state.event_status_mask[FLAG_MSB:FLAG_LSB] &
			state.event_status_mask[MASK_MSB:MASK_LSB]);

		// fast slew window restarts on every oscillator edge
		next_state.osc_prev = i_relax_osc;
		osc_edge = i_relax_osc ^ state.osc_prev;
		if (!state.fast_slew_control[SLEW_ENABLE_BIT]) begin
			next_state.slew_left = 7'h00;
		end else if (osc_edge) begin
			next_state.slew_left =
				state.fast_slew_control[SLEW_COUNT_MSB:SLEW_COUNT_LSB];
		end else if (state.slew_left != 7'h00) begin
			next_state.slew_left = state.slew_left - 7'h01;
		end
		next_state.fast_slew = (next_state.slew_left != 7'h00);

		// prescaler: free counter, tick when the low code+1 bits are all ones
		next_state.divider_count = state.divider_count + 8'h01;
		div_low_mask = 8'(9'h002 << div_code) - 8'h01;
		div_tick = prs_ctl[DIVIDER_BYPASS_BIT] ? 1'b1 :
			((state.divider_count & div_low_mask) == div_low_mask);
		// bypass cannot make a full-rate square from flops, so it shows div 2
		div_square = prs_ctl[DIVIDER_BYPASS_BIT] ? state.divider_count[0] :
			state.divider_count[div_code];

		// random sequence generator
		if (!prs_ctl[RANDOM_ENABLE_BIT]) begin
			next_state.random_state = RANDOM_SEED;
		end else if (div_tick) begin
			next_state.random_state =
				lfsr_step(state.random_state, prs_ctl[RANDOM_LEN_BIT]);
		end
		if (!prs_ctl[RANDOM_ENABLE_BIT]) begin
			next_state.random_out = 1'b0;
		end else if (prs_ctl[RANDOM_LEN_BIT]) begin
			next_state.random_out = next_state.random_state[11];
		end else begin
			next_state.random_out = next_state.random_state[7];
		end

		// sensing clock to the primary pin
		if (state.run_control[RUN_CSD_MODE_BIT]) begin
			sense_clock = state.run_control[RUN_PRS_CLOCK_BIT] ? state.random_out : div_square;
		end else begin
			sense_clock = i_selected_clock;
		end
		if (prs_ctl[CLOCK_OUT_BIT]) begin
			next_state.clock_pin = sense_clock ^ prs_ctl[CLOCK_INVERT_BIT];
		end else begin
			next_state.clock_pin = i_normal_output;
		end

		// dac code only reaches the converter while current mode is on
		next_state.dac_code = i_dac_mode ? next_state.current_dac_value : RESET_BYTE;

		// read data stands in the cycle after the read strobe
		if (i_bus.rd) begin
			case (i_bus.addr)
				ADDR_RUN_CONTROL: rd_mux = state.run_control;
				ADDR_COUNT_LOW: rd_mux = state.count_low;
				ADDR_COUNT_HIGH: rd_mux = state.count_high;
				ADDR_EVENT_STATUS_MASK: rd_mux = state.event_status_mask;
				ADDR_TIMER_INITIAL_COUNT: rd_mux = state.timer_initial_count;
				ADDR_FAST_SLEW_CONTROL: rd_mux = state.fast_slew_control;
				ADDR_RANDOM_SEQ_PRESCALER_CONTROL: rd_mux = prs_ctl;
				ADDR_CURRENT_DAC_VALUE: rd_mux = state.current_dac_value;
				default: rd_mux = RESET_BYTE;
			endcase
		end
		next_state.rdata = rd_mux;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= '0;
			state.random_state <= RANDOM_SEED;
		end else begin
			state <= next_state;
		end
	end

	assign o_rdata = state.rdata;
	assign o_block_irq = state.block_irq;
	assign o_timer_initial_count = state.timer_initial_count[TIMER_COUNT_MSB:0];
	assign o_fast_slew = state.fast_slew;
	assign o_random_out = state.random_out;
	assign o_clock_pin = state.clock_pin;
	assign o_current_dac_code = state.dac_code;

endmodule

// File: test/ssp_sense_regs_chk.sv
`timescale 1ns/1ns
module ssp_sense_regs_chk (
	// clock, reset and register port
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire ssp_pkg::ssp_bus_req_t i_bus,
	input wire logic [7:0] o_rdata,
	// sensing side
	input wire logic i_normal_output,
	input wire logic i_dac_mode,
	input wire logic i_selected_clock,
	input wire logic o_block_irq,
	input wire logic [6:0] o_timer_initial_count,
	input wire logic o_random_out,
	input wire logic o_clock_pin,
	input wire logic [7:0] o_current_dac_code
);
	import ssp_pkg::*;
	logic [7:0] prs_sh;
	logic [7:0] dac_sh;
	logic [7:0] run_sh;
	logic wr_run;
	logic wr_prs;
	logic wr_dac;
	assign wr_prs = i_bus.wr && i_bus.addr == ADDR_RANDOM_SEQ_PRESCALER_CONTROL;
	assign wr_dac = i_bus.wr && i_bus.addr == ADDR_CURRENT_DAC_VALUE;
	assign wr_run = i_bus.wr && i_bus.addr == ADDR_RUN_CONTROL;
	// shadows let pin and dac checks see the register contents
	always_ff @(posedge i_mclk) begin
		prs_sh <= i_rst ? RESET_BYTE : (wr_prs ? i_bus.wdata : prs_sh);
		dac_sh <= i_rst ? RESET_BYTE : (wr_dac ? i_bus.wdata : dac_sh);
		run_sh <= i_rst ? RESET_BYTE : (wr_run ? i_bus.wdata : run_sh);
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	a_read_idle_zero: assert property (!i_bus.rd |=> o_rdata == 8'h00)
		else $error("read data not zero after idle cycle");
	a_read_unmapped_zero: assert property (i_bus.rd && !(i_bus.addr inside {8'hA0, 8'hA4,
		8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hFD}) |=> o_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_timer_follows_write: assert property (i_bus.wr && i_bus.addr == ADDR_TIMER_INITIAL_COUNT
		|=> o_timer_initial_count == $past(i_bus.wdata[6:0]))
		else $error("timer count not taken from write");
	a_timer_read_match: assert property (i_bus.rd && i_bus.addr == ADDR_TIMER_INITIAL_COUNT
		|=> o_rdata == {1'b0, o_timer_initial_count})
		else $error("timer read differs from output");
	a_dac_code_gate: assert property (o_current_dac_code ==
		($past(i_dac_mode) ? dac_sh : 8'h00))
		else $error("dac code wrong");
	a_pin_normal_path: assert property (!prs_sh[CLOCK_OUT_BIT]
		|=> o_clock_pin == $past(i_normal_output))
		else $error("pin not on normal output");
	a_pin_invert_path: assert property (prs_sh[CLOCK_OUT_BIT] && !run_sh[RUN_CSD_MODE_BIT]
		|=> o_clock_pin == ($past(i_selected_clock) ^ $past(prs_sh[CLOCK_INVERT_BIT])))
		else $error("pin not on selected clock with polarity");
	a_random_off_zero: assert property (!prs_sh[RANDOM_ENABLE_BIT] |=> !o_random_out)
		else $error("random output not zero while off");
	a_disable_drops_irq: assert property (i_bus.wr && i_bus.addr == ADDR_RUN_CONTROL &&
		!i_bus.wdata[RUN_ENABLE_BIT] |-> ##3 !o_block_irq)
		else $error("irq kept after disable");
	a_no_mask_no_irq: assert property (i_bus.wr && i_bus.addr == ADDR_EVENT_STATUS_MASK &&
		i_bus.wdata[3:0] == 4'h0 |-> ##2 !o_block_irq)
		else $error("irq with all masks off");
endmodule
bind ssp_sense_regs ssp_sense_regs_chk u_chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus(i_bus),
	.o_rdata(o_rdata), .i_normal_output(i_normal_output), .i_dac_mode(i_dac_mode),
	.i_selected_clock(i_selected_clock),
	.o_block_irq(o_block_irq), .o_timer_initial_count(o_timer_initial_count),
	.o_random_out(o_random_out), .o_clock_pin(o_clock_pin),
	.o_current_dac_code(o_current_dac_code));

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
	import ssp_pkg::*;
	localparam logic [7:0] STA = ADDR_EVENT_STATUS_MASK;
	logic i_mclk, i_rst, i_event_in, i_measure_done, i_relax_osc, i_selected_clock;
	logic i_normal_output, i_dac_mode, o_block_irq, o_fast_slew, o_random_out, o_clock_pin;
	ssp_bus_req_t i_bus;
	logic [7:0] o_rdata, o_current_dac_code, v, r;
	logic [6:0] o_timer_initial_count;
	logic [7:0] adr[4];
	logic [7:0] msk[4];
	int bad_count, checked, seed, cyc, k, i;
	ssp_sense_regs DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata),
		.i_event_in(i_event_in), .i_measure_done(i_measure_done), .i_relax_osc(i_relax_osc),
		.i_selected_clock(i_selected_clock), .i_normal_output(i_normal_output),
		.i_dac_mode(i_dac_mode), .o_block_irq(o_block_irq),
		.o_timer_initial_count(o_timer_initial_count), .o_fast_slew(o_fast_slew),
		.o_random_out(o_random_out), .o_clock_pin(o_clock_pin),
		.o_current_dac_code(o_current_dac_code));
	initial begin
		i_mclk = 0;
		forever #50 i_mclk = ~i_mclk;
	end
	task close_out;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// run is about 72k cycles; the ceiling leaves margin
	always @(posedge i_mclk) begin
		i_normal_output <= $random(seed);
		i_selected_clock <= $random(seed);
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			close_out;
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		i_bus.wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		i_bus.rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	// counts high cycles over n cycles: 0 random output, 1 slew flag, 2 pin
	task count(input int n, input int s, output int c);
		c = 0;
		for (int j = 0; j < n; j++) begin
			tick(1);
			c += (s == 2) ? o_clock_pin : ((s == 1) ? o_fast_slew : o_random_out);
		end
	endtask
	// bypass shows a divide-by-two square on the pin
	function automatic int exp_period(input logic [7:0] ctl);
		exp_period = ctl[DIVIDER_BYPASS_BIT] ? 2 : (2 << ctl[DIVIDER_SELECT_MSB:0]);
	endfunction
	task per(output int p);
		p = 0;
		for (int n = 0; o_clock_pin !== 1'b0 && n < 600; n++) tick(1);
		for (int n = 0; o_clock_pin !== 1'b1 && n < 600; n++) tick(1);
		for (; o_clock_pin === 1'b1 && p < 600; p++) tick(1);
		for (; o_clock_pin === 1'b0 && p < 600; p++) tick(1);
	endtask
	initial begin
		adr = '{ADDR_TIMER_INITIAL_COUNT, ADDR_FAST_SLEW_CONTROL,
			ADDR_RANDOM_SEQ_PRESCALER_CONTROL, ADDR_CURRENT_DAC_VALUE};
		msk = '{8'h7F, 8'hFF, 8'hFF, 8'hFF};
		seed = 32'hC7C1;
		i_rst = 1;
		i_bus = '0;
		i_event_in = 0;
		i_measure_done = 0;
		i_relax_osc = 0;
		i_dac_mode = 0;
		bad_count = 0;
		checked = 0;
		repeat (2) @(posedge i_mclk);
		i_rst <= 0;
		rd(adr[2], r);
		chk(r, RESET_BYTE);
		for (i = 0; i < 8; i++) begin
			v = $random(seed);
			wr(adr[i % 4], v);
			rd(adr[i % 4], r);
			chk(r, v & msk[i % 4]);
		end
		wr(adr[0], 8'hD5);
		wr(adr[3], 8'h3C);
		i_dac_mode <= 1;
		tick(2);
		chk(o_timer_initial_count, 7'h55);
		chk(o_current_dac_code, 8'h3C);
		wr(8'hA3, 8'hFF);
		rd(8'hA3, r);
		chk(r, 8'h00);
		$display("registers done");
		wr(ADDR_RUN_CONTROL, 8'h01);
		i_event_in <= 1;
		i_measure_done <= 1;
		tick(1);
		i_measure_done <= 0;
		rd(STA, r);
		chk(r, 8'h90);
		wr(STA, 8'hF8);
		tick(3);
		chk(o_block_irq, 1'b1);
		wr(STA, 8'h7F);
		rd(STA, r);
		chk(r, 8'h1F);
		wr(STA, 8'hE8);
		rd(STA, r);
		chk(r, 8'h08);
		tick(300);
		rd(STA, r);
		chk(r, 8'h48);
		wr(STA, 8'h04);
		tick(300);
		chk(o_block_irq, 1'b1);
		tick(65000);
		rd(STA, r);
		chk(r, 8'h64);
		wr(ADDR_RUN_CONTROL, 8'h00);
		i_measure_done <= 1;
		rd(STA, r);
		chk(r, 8'h04);
		i_measure_done <= 0;
		rd(ADDR_COUNT_LOW, r);
		chk(r, 8'h00);
		$display("status done");
		wr(adr[2], 8'hC0);
		tick(20);
		wr(adr[2], 8'h80);
		tick(20);
		wr(ADDR_RUN_CONTROL, 8'h02);
		for (i = 0; i < 9; i++) begin
			v = i < 8 ? 8'h80 | 8'(i) : 8'h88;
			wr(adr[2], v);
			per(k);
			chk(16'(k), 16'(exp_period(v)));
		end
		wr(adr[2], 8'h18);
		count(255, 0, k);
		chk(16'(k), 16'd128);
		wr(adr[2], 8'h00);
		wr(adr[2], 8'h38);
		count(4095, 0, k);
		chk(16'(k), 16'd2048);
		wr(adr[2], 8'h00);
		wr(ADDR_RUN_CONTROL, 8'h06);
		wr(adr[2], 8'h98);
		count(255, 2, k);
		chk(16'(k), 16'd128);
		wr(adr[2], 8'h00);
		$display("prescaler done");
		wr(adr[1], 8'h0B);
		for (i = 0; i < 3; i++) begin
			if (i == 2)
				wr(adr[1], 8'h0A);
			i_relax_osc <= ~i_relax_osc;
			count(20, 1, k);
			chk(16'(k), i < 2 ? 16'd5 : 16'd0);
		end
		$display("slew done");
		close_out;
	end
endmodule
